// ---- hw/cmsc_cfg.svh ----
// constants for the cpu mode and status control block
`ifndef CMSC_CFG_SVH
`define CMSC_CFG_SVH
// status word low halfword fields
`define CMSC_PSW_C        0
`define CMSC_PSW_Z        1
`define CMSC_PSW_N        2
`define CMSC_PSW_V        3
`define CMSC_PSW_Q        4
`define CMSC_PSW_L        5
`define CMSC_PSW_T        14
`define CMSC_PSW_R        15
// status word high halfword fields
`define CMSC_PSW_GM       16
`define CMSC_PSW_IM_LSB   17
`define CMSC_PSW_EM       21
`define CMSC_PSW_MODE_LSB 22
`define CMSC_PSW_MODE_MSB 24
`define CMSC_PSW_WMASK    32'h01ff_c03f
`define CMSC_PSW_RESET    32'h0041_0000
// context ranks, lower is stronger
`define CMSC_RANK_NMI    3'h1
`define CMSC_RANK_EXC    3'h2
`define CMSC_RANK_IRQ3   3'h3
`define CMSC_RANK_IRQ0   3'h6
`define CMSC_RANK_NONE   3'h7
// register offsets, reset values and response codes
`define CMSC_OFF_PSW     8'h00
`define CMSC_OFF_CTX     8'h04
`define CMSC_OFF_PBASE   8'h08
`define CMSC_OFF_PLIM    8'h0c
`define CMSC_PBASE_RESET 32'hffff_ffff
`define CMSC_PLIM_RESET  32'h0000_0000
`define CMSC_RESP_OKAY   2'h0
`define CMSC_RESP_SLVERR 2'h2
`define CMSC_RESP_DECERR 2'h3
`endif

// ---- hw/cmsc_pkg.sv ----
// types for the cpu mode and status control block
package cmsc_pkg;
  `include "cmsc_cfg.svh"

  typedef enum logic [2:0] {
    CMSC_APP  = 3'h0,
    CMSC_SUP  = 3'h1,
    CMSC_IRQ0 = 3'h2,
    CMSC_IRQ1 = 3'h3,
    CMSC_IRQ2 = 3'h4,
    CMSC_IRQ3 = 3'h5,
    CMSC_EXC  = 3'h6,
    CMSC_NMI  = 3'h7
  } cmsc_mode_t;

  typedef struct packed {
    logic [31:0] psw;
    logic [31:0] pbase;
    logic [31:0] plim;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awrdy;
    logic        wrdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        entry;
    logic        push_gpr;
    logic [31:0] saved_psw;
    logic        restore;
    logic        instr_fault;
    logic        mem_grant;
    logic        mem_fault;
    logic        app_sp;
    logic        priv;
  } cmsc_state_t;

  // supervisor and application carry no rank
  function automatic logic [2:0] cmsc_rank(cmsc_mode_t m);
    case (m)
      CMSC_NMI:  cmsc_rank = `CMSC_RANK_NMI;
      CMSC_EXC:  cmsc_rank = `CMSC_RANK_EXC;
      CMSC_IRQ3: cmsc_rank = `CMSC_RANK_IRQ3;
      CMSC_IRQ2: cmsc_rank = 3'h4;
      CMSC_IRQ1: cmsc_rank = 3'h5;
      CMSC_IRQ0: cmsc_rank = `CMSC_RANK_IRQ0;
      default:   cmsc_rank = `CMSC_RANK_NONE;
    endcase
  endfunction
endpackage

// ---- hw/cmsc_arbiter.sv ----
// picks the strongest request that may preempt the running context
`timescale 1ns/1ps
`include "cmsc_cfg.svh"
module cmsc_arbiter import cmsc_pkg::*; (
  // requests
  input  wire logic [3:0] irq_req,
  input  wire logic       exc_req,
  input  wire logic       nmi_req,
  // current context
  input  wire logic [31:0] psw,
  // decision
  output      logic        take,
  output      cmsc_mode_t  tgt
);
  logic [2:0] cur_rank;
  logic [3:0] irq_ok;

  assign cur_rank = cmsc_rank(cmsc_mode_t'(psw[`CMSC_PSW_MODE_MSB:`CMSC_PSW_MODE_LSB]));

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lvl
      assign irq_ok[i] = irq_req[i] & ~psw[`CMSC_PSW_IM_LSB + i] & ~psw[`CMSC_PSW_GM] &
                         (cmsc_rank(cmsc_mode_t'(3'(CMSC_IRQ0 + i))) < cur_rank);
    end
  endgenerate

  always_comb begin
    take = 1'b1;
    tgt  = CMSC_SUP;
    if (nmi_req && (`CMSC_RANK_NMI < cur_rank)) begin
      tgt = CMSC_NMI;
    end else if (exc_req && (`CMSC_RANK_EXC < cur_rank)) begin
      tgt = CMSC_EXC;
    end else if (irq_ok[3]) begin
      tgt = CMSC_IRQ3;
    end else if (irq_ok[2]) begin
      tgt = CMSC_IRQ2;
    end else if (irq_ok[1]) begin
      tgt = CMSC_IRQ1;
    end else if (irq_ok[0]) begin
      tgt = CMSC_IRQ0;
    end else begin
      take = 1'b0;
    end
  end
endmodule // cmsc_arbiter

// ---- hw/cmsc_mode_status.sv ----
// execution context, status word and privilege checks with an axi4-lite port
// Behaviour
// - status word: flags low, mode/state high
// - low halfword resets to all zeros
// - ranks: nmi, exception, interrupt three..zero
// - supervisor, application unranked; application unprivileged
// - preempt only by strictly higher priority
// - software, interrupt and exception mode changes
// - application blocks privileged instructions, upper halfword
// - application refused protected memory
// - privileged contexts get full access
// - reset enters supervisor context
// - interrupt entry pushes r8-r12, return, status
`timescale 1ns/1ps
`include "cmsc_cfg.svh"
module cmsc_mode_status import cmsc_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // event sources
  input  wire logic [3:0]  irq_req,
  input  wire logic        exc_req,
  input  wire logic        nmi_req,
  input  wire logic        scall_req,
  input  wire logic        ret_req,
  input  wire logic [31:0] ret_status,
  // pipeline status and access checks
  input  wire logic        flags_we,
  input  wire logic [4:0]  flags_in,
  input  wire logic        psw_we,
  input  wire logic [31:0] psw_wdata,
  input  wire logic        priv_instr,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  // context outputs
  output      logic [31:0] processor_status_word,
  output      cmsc_mode_t  mode,
  output      logic        privileged,
  output      logic        application_stack_pointer_sel,
  output      logic        entry,
  output      logic        push_gpr,
  output      logic [31:0] saved_psw,
  output      logic        restore,
  output      logic        instr_fault,
  output      logic        mem_grant,
  output      logic        mem_fault
);
  cmsc_state_t q;
  cmsc_state_t d;
  logic        take;
  cmsc_mode_t  tgt;
  cmsc_mode_t  cur;
  logic        is_app;
  logic [31:0] wmask;

  cmsc_arbiter u_arb (
    .irq_req (irq_req),
    .exc_req (exc_req),
    .nmi_req (nmi_req),
    .psw     (q.psw),
    .take    (take),
    .tgt     (tgt)
  );

  assign cur    = cmsc_mode_t'(q.psw[`CMSC_PSW_MODE_MSB:`CMSC_PSW_MODE_LSB]);
  assign is_app = (cur == CMSC_APP);

  always_comb begin
    d             = q;
    d.entry       = 1'b0;
    d.push_gpr    = 1'b0;
    d.restore     = 1'b0;
    d.instr_fault = 1'b0;
    d.mem_grant   = 1'b0;
    d.mem_fault   = 1'b0;
    wmask         = 32'h0000_0000;

    // bus: address and data are taken in either order
    if (awvalid && q.awrdy) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wrdy) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `CMSC_RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        wmask[8*b +: 8] = {8{q.w_strb[b]}};
      end
      case (q.aw_addr)
        `CMSC_OFF_PSW: begin
          if (is_app) begin
            wmask = wmask & 32'h0000_ffff;
            if (q.w_strb[3:2] != 2'h0) begin
              d.bresp = `CMSC_RESP_SLVERR;
            end
          end
          d.psw = (q.psw & ~(wmask & `CMSC_PSW_WMASK)) | (q.w_data & wmask & `CMSC_PSW_WMASK);
        end
        `CMSC_OFF_PBASE, `CMSC_OFF_PLIM: begin
          if (is_app) begin
            d.bresp = `CMSC_RESP_SLVERR;
          end else if (q.aw_addr == `CMSC_OFF_PBASE) begin
            d.pbase = (q.w_data & wmask) | (q.pbase & ~wmask);
          end else begin
            d.plim = (q.w_data & wmask) | (q.plim & ~wmask);
          end
        end
        `CMSC_OFF_CTX: d.bresp = `CMSC_RESP_SLVERR;
        default:       d.bresp = `CMSC_RESP_DECERR;
      endcase
    end

    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp  = `CMSC_RESP_OKAY;
      case (araddr)
        `CMSC_OFF_PSW: begin
          // application sees only the low halfword
          d.rdata = is_app ? {16'h0000, q.psw[15:0]} : q.psw;
        end
        `CMSC_OFF_CTX:   d.rdata = {24'h00_0000, q.app_sp, !is_app, 3'(cmsc_rank(cur)),
                                    3'(cur)} >> 0;
        `CMSC_OFF_PBASE: d.rdata = q.pbase;
        `CMSC_OFF_PLIM:  d.rdata = q.plim;
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `CMSC_RESP_DECERR;
        end
      endcase
    end

    // hardware events follow the bus so they win a same-cycle clash
    // interrupt and exception entry
    if (take) begin
      d.saved_psw = d.psw;
      d.entry     = 1'b1;
      d.push_gpr  = (tgt != CMSC_EXC);
      d.psw[`CMSC_PSW_MODE_MSB:`CMSC_PSW_MODE_LSB] = tgt;
    end else if (ret_req) begin
      d.restore = 1'b1;
      d.psw     = ret_status & `CMSC_PSW_WMASK;
    end else if (scall_req && (cur == CMSC_APP || cur == CMSC_SUP)) begin
      d.saved_psw = d.psw;
      d.entry     = 1'b1;
      d.psw[`CMSC_PSW_MODE_MSB:`CMSC_PSW_MODE_LSB] = CMSC_SUP;
    end else if (psw_we) begin
      if (is_app) begin
        d.psw[15:0]   = psw_wdata[15:0] & 16'(`CMSC_PSW_WMASK);
        d.instr_fault = (psw_wdata[31:16] != q.psw[31:16]);
      end else begin
        d.psw = psw_wdata & `CMSC_PSW_WMASK;
      end
    end else if (flags_we) begin
      // condition flags sit in the low bits
      d.psw[4:0] = flags_in;
    end

    if (priv_instr && is_app) begin
      d.instr_fault = 1'b1;
    end
    if (mem_req) begin
      if (is_app && mem_addr >= q.pbase && mem_addr <= q.plim) begin
        d.mem_fault = 1'b1;
      end else begin
        d.mem_grant = 1'b1;
      end
    end

    d.app_sp = (d.psw[`CMSC_PSW_MODE_MSB:`CMSC_PSW_MODE_LSB] == CMSC_APP);
    // registered so the output comes straight from a flop
    d.priv   = !d.app_sp;
    d.awrdy  = !d.aw_have;
    d.wrdy   = !d.w_have;
    d.arrdy  = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.psw      <= `CMSC_PSW_RESET;
      q.priv     <= 1'b1;
      q.pbase    <= `CMSC_PBASE_RESET;
      q.plim     <= `CMSC_PLIM_RESET;
      q.awrdy    <= 1'b1;
      q.wrdy     <= 1'b1;
      q.arrdy    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready                       = q.awrdy;
  assign wready                        = q.wrdy;
  assign bvalid                        = q.bvalid;
  assign bresp                         = q.bresp;
  assign arready                       = q.arrdy;
  assign rvalid                        = q.rvalid;
  assign rdata                         = q.rdata;
  assign rresp                         = q.rresp;
  assign processor_status_word         = q.psw;
  assign mode                          = cur;
  assign privileged                    = q.priv;
  assign application_stack_pointer_sel = q.app_sp;
  assign entry                         = q.entry;
  assign push_gpr                      = q.push_gpr;
  assign saved_psw                     = q.saved_psw;
  assign restore                       = q.restore;
  assign instr_fault                   = q.instr_fault;
  assign mem_grant                     = q.mem_grant;
  assign mem_fault                     = q.mem_fault;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  low_reset_zero_a: assert property ($rose(aresetn) |-> q.psw[15:0] == 16'h0000)
    else $error("low status halfword not zero after reset");
  reset_sup_a: assert property ($rose(aresetn) |-> cur == CMSC_SUP)
    else $error("not in supervisor after reset");
  nmi_preempt_a: assert property (nmi_req && cur != CMSC_NMI |=> entry && cur == CMSC_NMI)
    else $error("nmi did not preempt");
  strict_preempt_a: assert property (entry && cur != CMSC_SUP |->
      cmsc_rank(cur) < cmsc_rank(cmsc_mode_t'($past(q.psw[24:22]))))
    else $error("preempted by equal or lower priority");
  unranked_a: assert property (cur == CMSC_SUP || cur == CMSC_APP |-> cmsc_rank(cur) == 3'h7)
    else $error("supervisor or application carries a rank");
  app_instr_trap_a: assert property (priv_instr && is_app |=> instr_fault)
    else $error("privileged instruction not trapped");
  app_upper_lock_a: assert property (psw_we && is_app && !take && !ret_req && !scall_req
      |=> q.psw[31:16] == $past(q.psw[31:16]))
    else $error("application changed upper halfword");
  mem_deny_a: assert property (mem_req && is_app && mem_addr >= q.pbase && mem_addr <= q.plim
      |=> mem_fault && !mem_grant)
    else $error("protected access not refused");
  priv_grant_a: assert property (mem_req && !is_app |=> mem_grant && !mem_fault)
    else $error("privileged access not granted");
  irq_push_a: assert property (entry && cur != CMSC_EXC && cur != CMSC_SUP
      |-> push_gpr && saved_psw == $past(q.psw))
    else $error("interrupt entry did not push context");
  ret_restore_a: assert property (ret_req && !take |=> restore ##1 !restore)
    else $error("return did not restore once");
  sp_select_a: assert property (q.app_sp == is_app)
    else $error("stack pointer select disagrees with mode");
  scall_entry_a: assert property (scall_req && is_app && !take && !ret_req
      |=> entry && cur == CMSC_SUP)
    else $error("software call did not enter supervisor");
  wr_resp_a: assert property (q.aw_have && q.w_have && !q.bvalid |=> bvalid)
    else $error("write answer missing");
  exc_preempt_a: assert property (exc_req && !nmi_req && cmsc_rank(cur) > `CMSC_RANK_EXC
      |=> entry && cur == CMSC_EXC)
    else $error("exception did not preempt");
  app_read_mask_a: assert property (arvalid && arready && araddr == `CMSC_OFF_PSW && is_app
      |=> rdata[31:16] == 16'h0000)
    else $error("application read saw upper halfword");
  sys_reg_lock_a: assert property (q.aw_have && q.w_have && !q.bvalid && is_app &&
      q.aw_addr == `CMSC_OFF_PBASE |=> bresp == `CMSC_RESP_SLVERR && $stable(q.pbase))
    else $error("application wrote a system register");
  priv_no_trap_a: assert property (priv_instr && !is_app |=> !instr_fault)
    else $error("privileged context trapped an instruction");
  mem_free_a: assert property (mem_req && is_app && (mem_addr < q.pbase || mem_addr > q.plim)
      |=> mem_grant && !mem_fault)
    else $error("unprotected access refused");
  priv_level_a: assert property (privileged == !is_app)
    else $error("privilege output disagrees with mode");
  scall_nopush_a: assert property (entry && cur == CMSC_SUP |-> !push_gpr)
    else $error("software call pushed general registers");
  gm_mask_a: assert property (entry && $past(q.psw[`CMSC_PSW_GM])
      |-> cur == CMSC_SUP || cur == CMSC_EXC || cur == CMSC_NMI)
    else $error("interrupt taken while globally masked");
  flags_write_a: assert property (flags_we && !take && !ret_req && !scall_req && !psw_we
      |=> processor_status_word[4:0] == $past(flags_in))
    else $error("condition flags not written");
  restore_value_a: assert property (ret_req && !take
      |=> processor_status_word == ($past(ret_status) & `CMSC_PSW_WMASK))
    else $error("restored status word wrong");
  read_ans_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");

  nmi_entry_c: cover property (entry && cur == CMSC_NMI);
  irq_nest_c: cover property (entry && cur == CMSC_IRQ0 ##[1:20] entry && cur == CMSC_IRQ3);
  scall_c: cover property (entry && cur == CMSC_SUP);
  return_c: cover property (entry ##[1:20] restore);
  app_fault_c: cover property (mem_fault ##[1:20] instr_fault);
endmodule // cmsc_mode_status

// ---- testbench/cmsc_core_model.sv ----
// request sources of the core pipeline facing the mode block
`timescale 1ns/1ps
module cmsc_core_model import cmsc_pkg::*; (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench commands: {nmi, exc, irq3..irq0}
  input  wire logic [5:0] raise,
  input  wire logic       drop,
  // context feedback
  input  wire logic       entry,
  input  wire cmsc_mode_t mode,
  // level requests
  output      logic [3:0] irq_req,
  output      logic       exc_req,
  output      logic       nmi_req
);
  logic [5:0] req_q;
  logic [5:0] req_d;

  always_comb begin
    req_d = req_q | raise;
    if (entry && mode >= CMSC_IRQ0) begin
      req_d[mode - CMSC_IRQ0] = 1'b0;
    end
    if (drop) begin
      req_d = 6'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 6'h00;
    end else begin
      req_q <= req_d;
    end
  end

  assign irq_req = req_q[3:0];
  assign exc_req = req_q[4];
  assign nmi_req = req_q[5];
endmodule // cmsc_core_model

// ---- testbench/tb_cpu_mode_status_control.sv ----
// self-checking bench for the mode and status block
`timescale 1ns/1ps
module tb_cpu_mode_status_control import cmsc_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, mem_addr = 32'h0, ret_status = 32'h0;
  logic [31:0] psw_wdata = 32'h0040_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        scall_req = 1'b0, ret_req = 1'b0, psw_we = 1'b0, flags_we = 1'b0;
  logic        priv_instr = 1'b0, mem_req = 1'b0, drop = 1'b0;
  logic [4:0]  flags_in = 5'h0a;
  logic [5:0]  raise = 6'h00;
  logic        awready, wready, bvalid, arready, rvalid, exc_req, nmi_req;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, psw, saved_psw;
  logic [3:0]  irq_req;
  cmsc_mode_t  mode;
  logic        privileged, sp_sel, entry, push_gpr, restore, instr_fault, mem_grant, mem_fault;
  int          n_fail = 0, compares = 0;

  always #50 aclk = ~aclk;

  cmsc_core_model core (.aclk(aclk), .aresetn(aresetn), .raise(raise), .drop(drop),
    .entry(entry), .mode(mode), .irq_req(irq_req), .exc_req(exc_req), .nmi_req(nmi_req));

  cmsc_mode_status DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq_req(irq_req), .exc_req(exc_req), .nmi_req(nmi_req), .scall_req(scall_req),
    .ret_req(ret_req), .ret_status(ret_status), .flags_we(flags_we), .flags_in(flags_in),
    .psw_we(psw_we), .psw_wdata(psw_wdata), .priv_instr(priv_instr), .mem_req(mem_req),
    .mem_addr(mem_addr), .processor_status_word(psw), .mode(mode), .privileged(privileged),
    .application_stack_pointer_sel(sp_sel), .entry(entry), .push_gpr(push_gpr),
    .saved_psw(saved_psw), .restore(restore), .instr_fault(instr_fault),
    .mem_grant(mem_grant), .mem_fault(mem_fault));

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // a wait that runs out ends the run
  task automatic tmo(input int i);
    if (i >= 100) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(i);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(i);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // one-cycle pipeline event: {scall, ret, psw_we, flags_we, priv_instr, mem_req}
  task automatic pl(input logic [5:0] k, input logic [31:0] a);
    @(posedge aclk);
    {scall_req, ret_req, psw_we, flags_we, priv_instr, mem_req} <= k;
    mem_addr <= a;
    @(posedge aclk);
    {scall_req, ret_req, psw_we, flags_we, priv_instr, mem_req} <= 6'h00;
    #1;
  endtask

  task automatic ent(input logic [5:0] r, input logic e, input cmsc_mode_t m, input logic pg);
    int i;
    @(posedge aclk);
    raise <= r;
    @(posedge aclk);
    raise <= 6'h00;
    for (i = 0; i < 8; i++) begin
      @(posedge aclk);
      #1;
      if (entry === 1'b1) break;
    end
    chk("entry", 32'(i < 8), 32'(e));
    chk("mode", 32'(mode), 32'(m));
    chk("push_gpr", 32'(push_gpr), 32'(pg));
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("psw", psw, 32'h0041_0000);
    chk("mode", 32'(mode), 32'(CMSC_SUP));
    chk("privileged", 32'(privileged), 32'h1);
    chk("sp_sel", 32'(sp_sel), 32'h0);
    rd(8'h00, 32'h0041_0000, `CMSC_RESP_OKAY);
    rd(8'h10, 32'h0, `CMSC_RESP_DECERR);
    wr(8'h10, 32'h0, 4'hf, `CMSC_RESP_DECERR);
    wr(8'h00, 32'h0000_001f, 4'h1, `CMSC_RESP_OKAY);
    rd(8'h00, 32'h0041_001f, `CMSC_RESP_OKAY);
    // clear the global mask so interrupt levels can be taken
    wr(8'h00, 32'h0040_0000, 4'hc, `CMSC_RESP_OKAY);
    wr(8'h08, 32'h0000_1000, 4'hf, `CMSC_RESP_OKAY);
    wr(8'h0c, 32'h0000_1fff, 4'hf, `CMSC_RESP_OKAY);
    rd(8'h0c, 32'h0000_1fff, `CMSC_RESP_OKAY);
    wr(8'h04, 32'h0, 4'hf, `CMSC_RESP_SLVERR);
    rd(8'h04, 32'h0000_0079, `CMSC_RESP_OKAY);
    pl(6'h01, 32'h0000_1800);
    chk("mem_grant", 32'(mem_grant), 32'h1);
    pl(6'h02, 32'h0);
    chk("instr_fault", 32'(instr_fault), 32'h0);
    ent(6'h01, 1'b1, CMSC_IRQ0, 1'b1);
    chk("saved_psw", saved_psw, 32'h0040_001f);
    ent(6'h02, 1'b1, CMSC_IRQ1, 1'b1);
    ent(6'h01, 1'b0, CMSC_IRQ1, 1'b0);
    ent(6'h10, 1'b1, CMSC_EXC, 1'b0);
    ent(6'h10, 1'b0, CMSC_EXC, 1'b0);
    ent(6'h20, 1'b1, CMSC_NMI, 1'b1);
    ent(6'h08, 1'b0, CMSC_NMI, 1'b0);
    @(posedge aclk);
    drop <= 1'b1;
    ret_status <= 32'h0000_0005;
    @(posedge aclk);
    drop <= 1'b0;
    pl(6'h10, 32'h0);
    chk("mode", 32'(mode), 32'(CMSC_APP));
    chk("restore", 32'(restore), 32'h1);
    chk("privileged", 32'(privileged), 32'h0);
    chk("sp_sel", 32'(sp_sel), 32'h1);
    rd(8'h00, 32'h0000_0005, `CMSC_RESP_OKAY);
    wr(8'h00, 32'h0040_0000, 4'hc, `CMSC_RESP_SLVERR);
    wr(8'h08, 32'h0, 4'hf, `CMSC_RESP_SLVERR);
    chk("mode", 32'(mode), 32'(CMSC_APP));
    pl(6'h02, 32'h0);
    chk("instr_fault", 32'(instr_fault), 32'h1);
    pl(6'h08, 32'h0);
    chk("instr_fault", 32'(instr_fault), 32'h1);
    pl(6'h01, 32'h0000_1800);
    chk("mem_fault", 32'(mem_fault), 32'h1);
    chk("mem_grant", 32'(mem_grant), 32'h0);
    pl(6'h01, 32'h0000_2000);
    chk("mem_grant", 32'(mem_grant), 32'h1);
    pl(6'h04, 32'h0);
    chk("psw", psw, 32'h0000_000a);
    pl(6'h20, 32'h0);
    chk("mode", 32'(mode), 32'(CMSC_SUP));
    chk("entry", 32'(entry), 32'h1);
    chk("push_gpr", 32'(push_gpr), 32'h0);
    chk("sp_sel", 32'(sp_sel), 32'h0);
    give_verdict();
  end
endmodule // tb_cpu_mode_status_control
